// File: pkg/lpm_pkg.sv
package lpm_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int ENTRY_TIME_NS  = 1000;
	localparam int ENTRY_CYCLES   =
		(ENTRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_TIME_NS = 50;
	localparam int FILTER_CYCLES  =
		(FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register bus
	localparam int         AXI_ADDR_W = 4;
	localparam logic [1:0] CTRL_IDX   = 2'h0;
	localparam logic [1:0] STATUS_IDX = 2'h1;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLV   = 2'h2;
	localparam logic [1:0] RESP_DEC   = 2'h3;

	// control register fields
	localparam int         CTRL_W        = 4;
	localparam int         CT_EN_BIT     = 0;
	localparam int         CT_TYPE2_BIT  = 1;
	localparam int         CT_GOUT_BIT   = 2;
	localparam int         CT_GOE_BIT    = 3;
	localparam logic [3:0] CTRL_RESET    = 4'h0;

	// status register fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_PIN_BIT   = 4;
	localparam int ST_PLL_BIT   = 5;
	localparam int ST_REQ_BIT   = 6;

	// power state, one-hot
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_ARMING = 4'h2,
		ST_RETAIN = 4'h4,
		ST_IDLE   = 4'h8
	} lpm_state_e;

endpackage : lpm_pkg

// File: hw/lpm_pin_filter.sv
// three-stage synchroniser followed by a glitch filter
module lpm_pin_filter #(
	parameter int   FILTER_CYCLES = lpm_pkg::FILTER_CYCLES,
	parameter logic RESET_LEVEL   = 1'b1
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level
);

	localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_CYCLES - 1);

	if (FILTER_CYCLES < 1) begin : g_bad_filter
		$error("filter needs at least one cycle");
	end

	logic [2:0]       sync_reg;
	logic [2:0]       sync_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             level_reg;
	logic             level_next;

	// stage 1 feeds only stage 2; stages 2 and 3 are compared
	always_comb begin
		sync_next  = {sync_reg[1:0], pin};
		cnt_next   = '0;
		level_next = level_reg;
		if (sync_reg[1] == sync_reg[2] && sync_reg[2] != level_reg) begin
			if (cnt_reg == CNT_LAST) begin
				level_next = sync_reg[2];
			end else begin
				cnt_next = cnt_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_reg  <= {3{RESET_LEVEL}};
			cnt_reg   <= '0;
			level_reg <= RESET_LEVEL;
		end else begin
			sync_reg  <= sync_next;
			cnt_reg   <= cnt_next;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;

	// a change must be seen stable for the whole filter time
	chk_filter_stable : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		level_reg != $past(level_reg) |->
			$past(cnt_reg) == CNT_LAST && $past(sync_reg[2]) == level_reg)
		else $error("filtered level changed without a stable run");

endmodule : lpm_pin_filter

// File: hw/lpm_ctrl.sv
// Notes on behaviour
// - pin-only mode: retention begins 1 us after the retention pin goes low.
// - retention ends and normal work resumes when the pin returns high.
// - pin-only mode: the pin level alone decides entry and exit.
// - gated mode: entry depends on both pin and core request; exit depends on the pin alone.
// - retention keeps all register and memory contents, supplies stay on.
// - entering retention stops generated clocks; external clocks do not matter.
// - static idle with clocks stopped keeps all values; clocks alone switch it.
// - low on the pll power-down input turns the pll off, giving static idle.
// - the retention pin is glitch filtered against accidental entry or exit.
// - the retention pin is routed to core logic for its own decisions.
// - with retention unused the pin works as an ordinary i/o.
// - gated mode enters only with pin low and request high together.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
module lpm_ctrl #(
	parameter int ENTRY_CYCLES  = lpm_pkg::ENTRY_CYCLES,
	parameter int FILTER_CYCLES = lpm_pkg::FILTER_CYCLES
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	input  wire logic [lpm_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [lpm_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          retention_pin_n_in,
	output logic                               retention_pin_n_out,
	output logic                               retention_pin_n_oe,
	input  wire logic                          low_static_request,
	input  wire logic                          pll_off_n,
	output logic                               retention_pin_core,
	output logic                               retention_active,
	output logic                               gen_clk_en,
	output logic                               pll_en
);

	localparam int CNT_W = $clog2(ENTRY_CYCLES + 1);
	localparam logic [CNT_W-1:0] ARM_LAST = CNT_W'(ENTRY_CYCLES - 2);

	if (ENTRY_CYCLES < 2) begin : g_bad_entry
		$error("entry delay needs at least two cycles");
	end

	// filtered pin levels
	logic pin_level;
	logic pll_on;

	lpm_pin_filter #(
		.FILTER_CYCLES (FILTER_CYCLES),
		.RESET_LEVEL   (1'b1)
	) u_ret_filter (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin     (retention_pin_n_in),
		.level   (pin_level)
	);

	lpm_pin_filter #(
		.FILTER_CYCLES (FILTER_CYCLES),
		.RESET_LEVEL   (1'b1)
	) u_pll_filter (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin     (pll_off_n),
		.level   (pll_on)
	);

	// control register
	logic [lpm_pkg::CTRL_W-1:0] ctrl_reg;
	logic [lpm_pkg::CTRL_W-1:0] ctrl_next;
	logic                       ret_en;
	logic                       type2;

	assign ret_en = ctrl_reg[lpm_pkg::CT_EN_BIT];
	assign type2  = ctrl_reg[lpm_pkg::CT_TYPE2_BIT];

	// power state machine
	lpm_pkg::lpm_state_e state_reg;
	lpm_pkg::lpm_state_e state_next;
	logic [CNT_W-1:0]    cnt_reg;
	logic [CNT_W-1:0]    cnt_next;
	logic                want_entry;
	logic                in_retain;

	// pin low, and in gated mode request high together with it
	assign want_entry = ret_en && !pin_level &&
		(!type2 || low_static_request);
	assign in_retain  = (state_reg == lpm_pkg::ST_RETAIN);

	// next power state
	always_comb begin
		state_next = state_reg;
		cnt_next   = '0;
		unique case (state_reg)
			lpm_pkg::ST_ACTIVE: begin
				if (want_entry) begin
					state_next = lpm_pkg::ST_ARMING;
				end else if (!pll_on) begin
					state_next = lpm_pkg::ST_IDLE;
				end
			end
			lpm_pkg::ST_ARMING: begin
				if (!want_entry) begin
					state_next = lpm_pkg::ST_ACTIVE;
				end else if (cnt_reg == ARM_LAST) begin
					state_next = lpm_pkg::ST_RETAIN;
				end else begin
					cnt_next = cnt_reg + CNT_W'(1);
				end
			end
			lpm_pkg::ST_RETAIN: begin
				if (pin_level) begin
					state_next = lpm_pkg::ST_ACTIVE;
				end
			end
			lpm_pkg::ST_IDLE: begin
				if (pll_on) begin
					state_next = lpm_pkg::ST_ACTIVE;
				end else if (want_entry) begin
					state_next = lpm_pkg::ST_ARMING;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= lpm_pkg::ST_ACTIVE;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// outputs toward clocking and core
	logic ret_reg;
	logic ret_next;
	logic gclk_reg;
	logic gclk_next;
	logic pllen_reg;
	logic pllen_next;
	logic core_reg;
	logic core_next;
	logic pout_reg;
	logic pout_next;
	logic poe_reg;
	logic poe_next;

	always_comb begin
		ret_next   = (state_next == lpm_pkg::ST_RETAIN);
		gclk_next  = (state_next == lpm_pkg::ST_ACTIVE) ||
			(state_next == lpm_pkg::ST_ARMING);
		pllen_next = pll_on && (state_next != lpm_pkg::ST_RETAIN);
		core_next  = pin_level;
		// pin as plain i/o when unused
		pout_next  = ctrl_reg[lpm_pkg::CT_GOUT_BIT];
		poe_next   = !ret_en && ctrl_reg[lpm_pkg::CT_GOE_BIT];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ret_reg   <= 1'b0;
			gclk_reg  <= 1'b0;
			pllen_reg <= 1'b0;
			core_reg  <= 1'b1;
			pout_reg  <= 1'b0;
			poe_reg   <= 1'b0;
		end else begin
			ret_reg   <= ret_next;
			gclk_reg  <= gclk_next;
			pllen_reg <= pllen_next;
			core_reg  <= core_next;
			pout_reg  <= pout_next;
			poe_reg   <= poe_next;
		end
	end

	assign retention_active    = ret_reg;
	assign gen_clk_en          = gclk_reg;
	assign pll_en              = pllen_reg;
	assign retention_pin_core  = core_reg;
	assign retention_pin_n_out = pout_reg;
	assign retention_pin_n_oe  = poe_reg;

	// bus write channel
	logic                       awready_reg;
	logic                       awready_next;
	logic                       wready_reg;
	logic                       wready_next;
	logic                       aw_have_reg;
	logic                       aw_have_next;
	logic                       w_have_reg;
	logic                       w_have_next;
	logic [1:0]                 widx_reg;
	logic [1:0]                 widx_next;
	logic [lpm_pkg::CTRL_W-1:0] wdat_reg;
	logic [lpm_pkg::CTRL_W-1:0] wdat_next;
	logic                       wstb_reg;
	logic                       wstb_next;
	logic                       bvalid_reg;
	logic                       bvalid_next;
	logic [1:0]                 bresp_reg;
	logic [1:0]                 bresp_next;
	logic                       aw_hs;
	logic                       w_hs;

	assign aw_hs = s_axi_awvalid && awready_reg;
	assign w_hs  = s_axi_wvalid && wready_reg;

	// address and data in either order, then one response
	always_comb begin
		aw_have_next = aw_have_reg || aw_hs;
		w_have_next  = w_have_reg || w_hs;
		widx_next    = aw_hs ? s_axi_awaddr[3:2] : widx_reg;
		wdat_next    = w_hs ? s_axi_wdata[lpm_pkg::CTRL_W-1:0] : wdat_reg;
		wstb_next    = w_hs ? s_axi_wstrb[0] : wstb_reg;
		bvalid_next  = bvalid_reg && !s_axi_bready;
		bresp_next   = bresp_reg;
		ctrl_next    = ctrl_reg;
		if (aw_have_next && w_have_next && !bvalid_next) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = lpm_pkg::RESP_OKAY;
			if (widx_next == lpm_pkg::CTRL_IDX) begin
				if (in_retain) begin
					bresp_next = lpm_pkg::RESP_SLV;
				end else if (wstb_next) begin
					ctrl_next = wdat_next;
				end
			end else if (widx_next != lpm_pkg::STATUS_IDX) begin
				bresp_next = lpm_pkg::RESP_DEC;
			end
		end
		awready_next = !aw_have_next && !bvalid_next;
		wready_next  = !w_have_next && !bvalid_next;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			widx_reg    <= 2'h0;
			wdat_reg    <= '0;
			wstb_reg    <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= lpm_pkg::RESP_OKAY;
			ctrl_reg    <= lpm_pkg::CTRL_RESET;
		end else begin
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			widx_reg    <= widx_next;
			wdat_reg    <= wdat_next;
			wstb_reg    <= wstb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			ctrl_reg    <= ctrl_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	// bus read channel
	logic        arready_reg;
	logic        arready_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0]  rresp_reg;
	logic [1:0]  rresp_next;
	logic [31:0] status_word;

	// status word from live state
	always_comb begin
		status_word = '0;
		status_word[lpm_pkg::ST_STATE_LSB +: 4] = state_reg;
		status_word[lpm_pkg::ST_PIN_BIT]        = pin_level;
		status_word[lpm_pkg::ST_PLL_BIT]        = pll_on;
		status_word[lpm_pkg::ST_REQ_BIT]        = low_static_request;
	end

	always_comb begin
		rvalid_next = rvalid_reg && !s_axi_rready;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (s_axi_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = lpm_pkg::RESP_OKAY;
			rdata_next  = '0;
			if (s_axi_araddr[3:2] == lpm_pkg::CTRL_IDX) begin
				rdata_next[lpm_pkg::CTRL_W-1:0] = ctrl_reg;
			end else if (s_axi_araddr[3:2] == lpm_pkg::STATUS_IDX) begin
				rdata_next = status_word;
			end else begin
				rresp_next = lpm_pkg::RESP_DEC;
			end
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= lpm_pkg::RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// checks on the power sequence
	sequence s_ret_exit;
		in_retain && pin_level ##1 state_reg == lpm_pkg::ST_ACTIVE;
	endsequence

	sequence s_arm_abort;
		state_reg == lpm_pkg::ST_ARMING && !want_entry
		##1 state_reg == lpm_pkg::ST_ACTIVE && cnt_reg == '0;
	endsequence

	chk_entry_delay : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(ret_reg) |-> $past(cnt_reg) == ARM_LAST &&
			$past(state_reg) == lpm_pkg::ST_ARMING)
		else $error("retention entered before the entry delay");

	chk_pin_exit : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		in_retain && pin_level |-> s_ret_exit ##0 !ret_reg && gclk_reg)
		else $error("retention not left after pin release");

	chk_pin_only : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		state_reg == lpm_pkg::ST_ARMING && !type2 && pin_level
		|-> s_arm_abort)
		else $error("pin-only arming not cancelled by pin high");

	chk_gate_both : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(ret_reg) |-> $past(!pin_level) &&
			($past(!type2) || $past(low_static_request)))
		else $error("retention entered without both conditions");

	chk_gate_abort : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		state_reg == lpm_pkg::ST_ARMING && type2 &&
			!low_static_request |-> s_arm_abort)
		else $error("gated arming kept without core request");

	chk_regs_frozen : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		in_retain ##1 in_retain |-> $stable(ctrl_reg))
		else $error("settings changed during retention");

	chk_clk_gated : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		ret_reg |-> !gclk_reg && !pllen_reg)
		else $error("generated clocks running in retention");

	chk_idle_pll : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		state_reg == lpm_pkg::ST_ACTIVE && !pll_on && !want_entry
		|=> state_reg == lpm_pkg::ST_IDLE ##0 !pllen_reg && !gclk_reg)
		else $error("pll power-down did not give idle");

	chk_pin_routed : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		##1 core_reg == $past(pin_level))
		else $error("core copy of pin lags or differs");

	chk_gpio_mode : assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$past(ret_en) |-> !poe_reg)
		else $error("pin driven while retention in use");

endmodule : lpm_ctrl

// File: test/lpm_pin_partner.sv
// external party driving the retention pin, push-pull, no pull resistor
module lpm_pin_partner (
	input  wire logic ref_clk,
	output logic      pin_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// pin idles high, no retention requested
	initial pin_n = 1'b1;

	task automatic hold_level(input logic lvl, input int cycles);
		pin_n <= lvl;
		repeat (cycles) @(posedge ref_clk);
	endtask : hold_level

	task automatic glitch(input int cycles);
		pin_n <= 1'b0;
		repeat (cycles) @(posedge ref_clk);
		pin_n <= 1'b1;
	endtask : glitch
endmodule : lpm_pin_partner

// File: test/lpm_ctrl_test.sv
module lpm_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         ENT = 4;
	localparam int         FLT = 1;
	localparam int         LAT = ENT + FLT + 6;
	localparam logic [3:0] CTL = {lpm_pkg::CTRL_IDX, 2'b00};
	localparam logic [3:0] STA = {lpm_pkg::STATUS_IDX, 2'b00};
	logic        ref_clk, rst_n, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0]  awaddr, araddr, wstrb, s;
	logic [31:0] wdata, rdata, rd, d;
	logic [1:0]  bresp, rresp, rsp;
	logic        pin_out, pin_oe, pin_drv, pin_wire, req, pll_off_n;
	logic        pin_core, retention_active, gen_clk_en, pll_en;
	int          err_total, n_tests, cyc, ctrl_m, n;

	// pin level seen by everyone: block wins while it drives
	assign pin_wire = pin_oe ? pin_out : pin_drv;

	lpm_ctrl #(.ENTRY_CYCLES(ENT), .FILTER_CYCLES(FLT)) lpm_ctrl_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .retention_pin_n_in(pin_wire),
		.retention_pin_n_out(pin_out), .retention_pin_n_oe(pin_oe),
		.low_static_request(req), .pll_off_n(pll_off_n),
		.retention_pin_core(pin_core), .retention_active(retention_active),
		.gen_clk_en(gen_clk_en), .pll_en(pll_en)
	);

	lpm_pin_partner lpm_pin_partner_inst (.ref_clk(ref_clk), .pin_n(pin_drv));

	// clock generation
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	// one write: address and data offered together, response awaited
	task automatic axi_write(input logic [3:0] a, input logic [31:0] dv,
		input logic [3:0] sv);
		bit aw_ok;
		bit w_ok;
		@(posedge ref_clk);
		aw_ok = 0;
		w_ok = 0;
		awaddr <= a;
		wdata <= dv;
		wstrb <= sv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge ref_clk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [3:0] a);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : axi_read

	task automatic wait_ret(input logic want);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (retention_active !== want && n < 60);
	endtask : wait_ret

	task automatic chk_status(input logic [3:0] st);
		axi_read(STA);
		check(rd, {25'h0, req, pll_off_n, pin_drv, st}, "status");
	endtask : chk_status

	// main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, req} = '0;
		{awaddr, araddr, wstrb, wdata} = '0;
		pll_off_n = 1'b1;
		rst_n = 1'b0;
		n = $urandom(32'h76c6);
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check(gen_clk_en, 1, "clk en after reset");
		axi_read(CTL);
		check(rd, 0, "ctrl reset");
		chk_status(lpm_pkg::ST_ACTIVE);
		axi_read(4'h8);
		check(rsp, lpm_pkg::RESP_DEC, "unmapped read");
		axi_write(4'hc, 32'h1, 4'hf);
		check(rsp, lpm_pkg::RESP_DEC, "unmapped write");
		axi_write(STA, $urandom, 4'hf);
		check(rsp, lpm_pkg::RESP_OKAY, "status write");
		ctrl_m = 1;
		axi_write(CTL, 32'h1, 4'h1);
		lpm_pin_partner_inst.glitch(1);
		repeat (LAT + ENT) @(posedge ref_clk);
		check(retention_active, 0, "after glitch");
		lpm_pin_partner_inst.hold_level(1'b0, 1);
		wait_ret(1'b1);
		check(n >= ENT && n <= LAT, 1, "entry delay");
		check({gen_clk_en, pll_en}, 0, "clocks off");
		check(pin_core, 0, "pin to core");
		axi_write(CTL, 32'h0, 4'hf);
		check(rsp, lpm_pkg::RESP_SLV, "ctrl write retained");
		axi_read(CTL);
		check(rd, ctrl_m, "ctrl kept");
		chk_status(lpm_pkg::ST_RETAIN);
		lpm_pin_partner_inst.hold_level(1'b1, 1);
		wait_ret(1'b0);
		check(n <= LAT, 1, "exit delay");
		repeat (2) @(posedge ref_clk);
		check({gen_clk_en, pin_core}, 2'b11, "clock back");
		// short low run arms, then pin high cancels it
		lpm_pin_partner_inst.hold_level(1'b0, 2);
		lpm_pin_partner_inst.hold_level(1'b1, LAT + ENT);
		check(retention_active, 0, "arming cancelled");
		ctrl_m = 3;
		axi_write(CTL, 32'h3, 4'h1);
		lpm_pin_partner_inst.hold_level(1'b0, LAT + ENT + 4);
		check(retention_active, 0, "pin alone");
		// request dropped while arming cancels entry
		req <= 1'b1;
		repeat (2) @(posedge ref_clk);
		req <= 1'b0;
		repeat (ENT + 4) @(posedge ref_clk);
		check(retention_active, 0, "gated abort");
		req <= 1'b1;
		wait_ret(1'b1);
		check(n <= ENT + 3, 1, "gated entry");
		// request dropped by core, ignored in retention
		req <= 1'b0;
		repeat (ENT + 4) @(posedge ref_clk);
		check(retention_active, 1, "request drop");
		lpm_pin_partner_inst.hold_level(1'b1, 1);
		wait_ret(1'b0);
		lpm_pin_partner_inst.hold_level(1'b0, LAT + ENT + 4);
		check(retention_active, 0, "no reentry");
		lpm_pin_partner_inst.hold_level(1'b1, LAT);
		pll_off_n <= 1'b0;
		repeat (LAT) @(posedge ref_clk);
		check({pll_en, gen_clk_en}, 0, "pll off");
		chk_status(lpm_pkg::ST_IDLE);
		pll_off_n <= 1'b1;
		repeat (LAT) @(posedge ref_clk);
		check(pll_en, 1, "pll on");
		chk_status(lpm_pkg::ST_ACTIVE);
		// random control writes, pin as plain i/o
		for (int i = 0; i < 8; i++) begin
			d = $urandom & 32'hffff_fffe;
			s = 4'($urandom);
			axi_write(CTL, d, s);
			if (s[0]) begin
				ctrl_m = int'(d[3:0]);
			end
			axi_read(CTL);
			check(rd, ctrl_m, "ctrl readback");
			check(pin_oe, ctrl_m[3] && !ctrl_m[0], "gpio enable");
		end
		axi_write(CTL, 32'hc, 4'h1);
		lpm_pin_partner_inst.hold_level(1'b0, LAT + ENT + 4);
		check({pin_oe, pin_out}, 2'b11, "gpio drive");
		check(retention_active, 0, "pin ignored");
		report_and_stop();
	end
endmodule : lpm_ctrl_test
